// File: rtl/bridge_reset_and_msi_irq_outputs.sv
// Reset outputs and MSI interrupt outputs of a bus-to-PCIe bridge.
// Assumes pclk at 100 MHz and link status synchronous to pclk.
`timescale 1ns/1ps
module bridge_reset_and_msi_irq_outputs
    import bridge_rst_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [31:0]  msi_low_events,
    input  wire logic [31:0]  msi_high_events,
    input  wire link_status_t link_status,
    input  wire logic         soft_bridge_reset_n,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              main_bus_reset_n,
    output logic              lite_control_port_reset_n,
    output logic              msi_low_vector_irq,
    output logic              msi_high_vector_irq
);
    logic [31:0] ctrl;
    logic [31:0] msi_low;
    logic [31:0] msi_low_mask;
    logic [31:0] msi_high;
    logic [31:0] msi_high_mask;
    logic        soft_n_q;

    // Address decode, shared by reads and writes.
    wire access    = psel && penable;
    wire wr        = access && pwrite;
    wire sel_ctrl  = paddr == CTRL_OFFSET;
    wire sel_stat  = paddr == STATUS_OFFSET;
    wire sel_lo    = paddr == MSI_LOW_OFFSET;
    wire sel_lom   = paddr == MSI_LOW_MASK_OFF;
    wire sel_hi    = paddr == MSI_HI_OFFSET;
    wire sel_him   = paddr == MSI_HI_MASK_OFF;
    wire mapped    = sel_ctrl | sel_stat | sel_lo | sel_lom | sel_hi | sel_him;

    wire root_port  = ctrl[CTRL_ROOT_PORT_BIT];
    wire irq_decode = ctrl[CTRL_IRQ_DECODE_BIT];
    wire subsystem  = ctrl[CTRL_SUBSYSTEM_BIT];
    wire soft_en    = ctrl[CTRL_SOFT_EN_BIT];

    // Soft reset only counts when the option is present.
    wire soft_active = subsystem && soft_en && !soft_n_q;
    // Software-triggered soft reset bit for in-system use.
    wire sw_soft     = ctrl[CTRL_SOFT_RST_BIT];
    wire bridge_clr  = soft_active || (subsystem && soft_en && sw_soft);

    // Release conditions by variant and port mode.
    wire main_ok = root_port ? (subsystem && link_status.phy_ready)
                             : link_status.d0_active;
    // Standalone control reset ignores link state.
    wire ctl_ok  = !subsystem ? 1'b1
                 : (root_port ? link_status.phy_ready
                              : link_status.d0_active);

    wire [31:0] status_word = {27'h0, soft_active,
                               link_status.phy_ready,
                               link_status.d0_active,
                               lite_control_port_reset_n,
                               main_bus_reset_n};

    // Soft reset sampled once; input is synchronous to pclk.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_n_q <= 1'b1;
        else
            soft_n_q <= soft_bridge_reset_n;
    end

    // Control register survives a soft reset, so the option bits stay set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= CTRL_RESET;
        else if (wr && sel_ctrl)
            ctrl <= pwdata;
    end

    // Decode registers: events set, write-one clears, set wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msi_low       <= '0;
            msi_high      <= '0;
            msi_low_mask  <= MASK_RESET;
            msi_high_mask <= MASK_RESET;
        end
        else if (bridge_clr)
        begin
            msi_low       <= '0;
            msi_high      <= '0;
            msi_low_mask  <= MASK_RESET;
            msi_high_mask <= MASK_RESET;
        end
        else
        begin
            msi_low  <= (msi_low & ~((wr && sel_lo) ? pwdata : 32'h0))
                        | msi_low_events;
            msi_high <= (msi_high & ~((wr && sel_hi) ? pwdata : 32'h0))
                        | msi_high_events;
            if (wr && sel_lom)
                msi_low_mask <= pwdata;
            if (wr && sel_him)
                msi_high_mask <= pwdata;
        end
    end

    // Interrupt outputs from flops; both vectors gated by mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msi_low_vector_irq  <= 1'b0;
            msi_high_vector_irq <= 1'b0;
        end
        else
        begin
            msi_low_vector_irq  <= root_port && irq_decode &&
                                   |(msi_low & ~msi_low_mask);
            msi_high_vector_irq <= root_port && irq_decode &&
                                   |(msi_high & ~msi_high_mask);
        end
    end

    // APB answers with zero wait states; unmapped addresses raise pslverr.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= sel_ctrl ? ctrl
                     : sel_stat ? status_word
                     : sel_lo   ? msi_low
                     : sel_lom  ? msi_low_mask
                     : sel_hi   ? msi_high
                     : sel_him  ? msi_high_mask
                     : 32'h0;
        end
    end

    // Asynchronous assert, synchronous release of both outputs.
    wire main_rel = main_ok && !bridge_clr;
    wire ctl_rel  = ctl_ok && !bridge_clr;

    reset_release_sync #(.STAGES(2)) u_main_sync
    (
        .clk        (pclk),
        .arst_n     (presetn),
        .release_ok (main_rel),
        .rst_n      (main_bus_reset_n)
    );

    // Two flops give the two-cycle release after primary reset.
    reset_release_sync #(.STAGES(CTL_RELEASE_CYCLES)) u_ctl_sync
    (
        .clk        (pclk),
        .arst_n     (presetn),
        .release_ok (ctl_rel),
        .rst_n      (lite_control_port_reset_n)
    );

    // Every bridge clear pulls both outputs low on the next edge.
    chk_soft_holds_resets: assert property (
        @(posedge pclk) disable iff (!presetn)
        bridge_clr |=> !main_bus_reset_n && !lite_control_port_reset_n)
        else $error("Soft reset did not assert resets");
    // Either vector may only rise when root port decode mode was set.
    chk_high_irq_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        msi_high_vector_irq |-> $past(root_port && irq_decode))
        else $error("High irq outside root decode mode");
    chk_low_irq_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        msi_low_vector_irq |-> $past(root_port && irq_decode))
        else $error("Low irq outside root decode mode");
    chk_high_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (root_port && irq_decode && |(msi_high & ~msi_high_mask))
        |=> msi_high_vector_irq)
        else $error("High irq missing");
    chk_low_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (root_port && irq_decode && |(msi_low & ~msi_low_mask))
        |=> msi_low_vector_irq)
        else $error("Low irq missing");
    // A reset chain clears on the edge after its cause drops.
    chk_ep_main_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!root_port && !link_status.d0_active) |=> !main_bus_reset_n)
        else $error("Main reset released before D0");
    chk_rp_main_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        (subsystem && root_port && link_status.phy_ready && !bridge_clr)[*3]
        |-> main_bus_reset_n)
        else $error("Main reset not released on phy ready");
    // Standalone control reset stays low for two edges after release.
    chk_ctl_held_early: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !lite_control_port_reset_n
        ##1 !lite_control_port_reset_n)
        else $error("Control reset released too early");
    chk_ctl_two_cycles: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) ##0 (!subsystem)[*3] |-> lite_control_port_reset_n)
        else $error("Control reset not released after two cycles");
    chk_ss_ep_ctl_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (subsystem && !root_port && !link_status.d0_active)
        |=> !lite_control_port_reset_n)
        else $error("Lite control reset released before D0");
    chk_ss_rp_ctl_rel: assert property (
        @(posedge pclk) disable iff (!presetn)
        (subsystem && root_port && link_status.phy_ready && !bridge_clr)[*3]
        |-> lite_control_port_reset_n)
        else $error("Lite control reset not released");
    // Without the option the soft pin cannot hold the main reset down.
    chk_soft_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!(subsystem && soft_en) && main_ok)[*3] |-> main_bus_reset_n)
        else $error("Soft reset honoured without option");
    chk_sync_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(main_bus_reset_n) |-> $past(main_rel, 2))
        else $error("Main reset released without two-cycle cause");
endmodule

// File: rtl/bridge_rst_pkg.sv
// Package for the bridge reset and interrupt output block.
// Assumes a single 100 MHz pclk domain and APB register access.
package bridge_rst_pkg;
    // Register byte offsets.
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] STATUS_OFFSET    = 12'h004;
    localparam logic [11:0] MSI_LOW_OFFSET   = 12'h008;
    localparam logic [11:0] MSI_LOW_MASK_OFF = 12'h00C;
    localparam logic [11:0] MSI_HI_OFFSET    = 12'h010;
    localparam logic [11:0] MSI_HI_MASK_OFF  = 12'h014;
    // Control field positions.
    localparam int CTRL_ROOT_PORT_BIT  = 0;
    localparam int CTRL_IRQ_DECODE_BIT = 1;
    localparam int CTRL_SUBSYSTEM_BIT  = 2;
    localparam int CTRL_SOFT_EN_BIT    = 3;
    localparam int CTRL_SOFT_RST_BIT   = 4;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;
    // Control-port release delay after primary reset, in clock cycles.
    localparam int CTL_RELEASE_CYCLES = 2;
    // Minimum soft reset hold time.
    localparam int SOFT_HOLD_MS = 50;
    localparam int CLK_MHZ = 100;
    localparam int SOFT_HOLD_CYCLES = SOFT_HOLD_MS * 1000 * CLK_MHZ;

    // Link status inputs grouped together.
    typedef struct packed {
        logic d0_active;
        logic phy_ready;
    } link_status_t;
endpackage

// File: rtl/reset_release_sync.sv
// Release synchroniser for one reset output.
// Assumes an active-low asynchronous assert and a clock that runs.
`timescale 1ns/1ps
module reset_release_sync
    import bridge_rst_pkg::*;
#(
    parameter int STAGES = 2
)
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic release_ok,
    output logic      rst_n
);
    logic [STAGES-1:0] chain;

    // Assertion by arst_n is immediate, by release_ok on the next edge; release walks through the chain.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            chain <= '0;
        else
            chain <= release_ok ? {chain[STAGES-2:0], 1'b1} : '0;
    end

    assign rst_n = chain[STAGES-1];
endmodule

// File: dv/link_side_model.sv
// Far-side model: link status source and soft reset driver.
// Assumes the one pclk domain of the bridge block.
`timescale 1ns/1ps
module link_side_model
    import bridge_rst_pkg::*;
#(
    parameter int DELAY = 3,
    parameter int HOLD  = 20
)
(
    input  wire logic    pclk,
    input  wire logic    want_d0,
    input  wire logic    want_phy,
    input  wire logic    soft_req,
    output link_status_t link_status,
    output logic         soft_bridge_reset_n
);
    logic [7:0] d0_dly;
    logic [7:0] phy_dly;
    int         hold_cnt = 0;
    // Status lags the request so the bridge sees a slow link come up.
    always @(posedge pclk)
    begin
        d0_dly  <= {d0_dly[6:0], want_d0};
        phy_dly <= {phy_dly[6:0], want_phy};
        // Hold is shortened from the minimum soft reset hold time.
        hold_cnt <= soft_req ? HOLD : (hold_cnt > 0 ? hold_cnt - 1 : 0);
    end
    assign link_status.d0_active = d0_dly[DELAY];
    assign link_status.phy_ready = phy_dly[DELAY];
    // The bench only pulses it with no traffic running.
    assign soft_bridge_reset_n   = (hold_cnt == 0);
endmodule

// File: dv/bridge_reset_and_msi_irq_outputs_tb.sv
// Self-checking bench for the bridge reset and interrupt block.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/1ps
module bridge_reset_and_msi_irq_outputs_tb;
    import bridge_rst_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, msi_low_events = 0, msi_high_events = 0;
    logic [31:0] prdata, rd;
    logic want_d0 = 0, want_phy = 0, soft_req = 0, soft_n, er;
    logic pready, pslverr, main_rst_n, lite_rst_n, irq_lo, irq_hi;
    link_status_t link_status;
    int errors = 0, checks_done = 0, cycles = 0;
    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;
    bridge_reset_and_msi_irq_outputs bridge_reset_and_msi_irq_outputs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .msi_low_events(msi_low_events), .msi_high_events(msi_high_events),
        .link_status(link_status), .soft_bridge_reset_n(soft_n),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_bus_reset_n(main_rst_n), .lite_control_port_reset_n(lite_rst_n),
        .msi_low_vector_irq(irq_lo), .msi_high_vector_irq(irq_hi));
    link_side_model link_side_model_inst (
        .pclk(pclk), .want_d0(want_d0), .want_phy(want_phy),
        .soft_req(soft_req), .link_status(link_status),
        .soft_bridge_reset_n(soft_n));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // A hang counts as a mismatch rather than running forever.
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready without assuming a latency.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Only the bench timeout ends a wait for pready.
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic test_regs;
        apb(0, CTRL_OFFSET, 0);
        chk(rd, CTRL_RESET);
        apb(0, MSI_HI_MASK_OFF, 0);
        chk(rd, MASK_RESET);
        apb(1, 12'h020, 32'h1234_5678);
        chk(er, 1);
        apb(0, 12'h020, 0);
        chk(rd, 0);
        $display("test_regs done");
    endtask
    task automatic test_release;
        apb(1, CTRL_OFFSET, 32'h0000_0004);
        wait_cyc(4);
        chk(main_rst_n, 0);
        want_d0 <= 1;
        wait_cyc(10);
        chk({main_rst_n, lite_rst_n}, 2'b11);
        apb(0, STATUS_OFFSET, 0);
        chk(rd, 32'h0000_0007);
        want_d0 <= 0;
        apb(1, CTRL_OFFSET, 32'h0000_0005);
        wait_cyc(10);
        chk({main_rst_n, lite_rst_n}, 2'b00);
        want_phy <= 1;
        wait_cyc(10);
        chk({main_rst_n, lite_rst_n}, 2'b11);
        $display("test_release done");
    endtask
    task automatic test_irq;
        apb(1, CTRL_OFFSET, 32'h0000_0007);
        apb(1, MSI_HI_MASK_OFF, 32'hFFFF_FFFE);
        @(posedge pclk);
        msi_high_events <= 32'h0000_0003;
        msi_low_events <= 32'h0000_0001;
        @(posedge pclk);
        msi_high_events <= 0;
        msi_low_events <= 0;
        wait_cyc(3);
        chk({irq_hi, irq_lo}, 2'b10);
        apb(1, MSI_LOW_MASK_OFF, 32'hFFFF_FFFE);
        wait_cyc(3);
        chk(irq_lo, 1);
        apb(1, CTRL_OFFSET, 32'h0000_0005);
        wait_cyc(3);
        chk({irq_hi, irq_lo}, 2'b00);
        apb(1, CTRL_OFFSET, 32'h0000_0007);
        wait_cyc(3);
        chk({irq_hi, irq_lo}, 2'b11);
        apb(1, MSI_HI_OFFSET, 32'h0000_0001);
        wait_cyc(3);
        chk(irq_hi, 0);
        $display("test_irq done");
    endtask
    task automatic test_soft;
        apb(1, CTRL_OFFSET, 32'h0000_0005);
        @(posedge pclk);
        soft_req <= 1;
        @(posedge pclk);
        soft_req <= 0;
        wait_cyc(8);
        chk(main_rst_n, 1);
        wait_cyc(20);
        apb(1, CTRL_OFFSET, 32'h0000_000D);
        @(posedge pclk);
        soft_req <= 1;
        @(posedge pclk);
        soft_req <= 0;
        wait_cyc(8);
        chk({main_rst_n, lite_rst_n}, 2'b00);
        wait_cyc(30);
        chk({main_rst_n, lite_rst_n}, 2'b11);
        apb(0, MSI_HI_MASK_OFF, 0);
        chk(rd, MASK_RESET);
        apb(0, MSI_LOW_OFFSET, 0);
        chk(rd, 0);
        $display("test_soft done");
    endtask
    // Main sequence; standalone control reset is judged right after reset.
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        wait_cyc(1);
        chk(lite_rst_n, 0);
        wait_cyc(4);
        chk({main_rst_n, lite_rst_n}, 2'b01);
        test_regs();
        test_release();
        test_irq();
        test_soft();
        tally_and_finish();
    end
endmodule
